// ---- bench/rstc_peer_rail.sv ----
// Peer rail model broadcasting events on the rail event bus
`timescale 1ns/1ps
`default_nettype none
module rstc_peer_rail (
    // Clock
    input  wire logic       sys_clk_in,
    // Broadcast request
    input  wire logic       send_in,
    input  wire logic [2:0] kind_in,
    input  wire logic [4:0] rail_in,
    // Rail event bus
    output var  logic       evt_valid_out,
    output var  logic [2:0] evt_type_out,
    output var  logic [4:0] evt_rail_out
);
    initial begin
        evt_valid_out = 1'b0;
        evt_type_out  = 3'h0;
        evt_rail_out  = 5'h0;
    end
    // One-cycle event, lines scrambled while idle
    always @(posedge sys_clk_in) begin
        if (send_in) begin
            evt_valid_out <= 1'b1;
            evt_type_out  <= kind_in;
            evt_rail_out  <= rail_in;
        end else begin
            evt_valid_out <= 1'b0;
            evt_type_out  <= ~evt_type_out;
            evt_rail_out  <= ~evt_rail_out;
        end
    end
endmodule : rstc_peer_rail
`default_nettype wire

// ---- bench/test_rail_sequence_track_config.sv ----
// Self-checking bench for the rail sequence and tracking config bank
`timescale 1ns/1ps
`default_nettype none
module test_rail_sequence_track_config;
    logic        sys_clk_in     = 1'b0;
    logic        rst_n_in       = 1'b0;
    logic        cmd_wr_in      = 1'b0;
    logic        cmd_rd_in      = 1'b0;
    logic [7:0]  cmd_code_in    = 8'h00;
    logic [55:0] cmd_wdata_in   = 56'h0;
    logic [11:0] strap_kind_in  = 12'hFE4;
    logic [29:0] strap_res_in   = 30'h01F2_8000;
    logic [15:0] vin_meas_in    = 16'h2EE0;
    logic [15:0] vout_target_in = 16'h0CE4;
    logic [15:0] strap_order_in = 16'h0000;
    logic        enable_pin_in  = 1'b0;
    logic        op_enable_in   = 1'b0;
    logic        multi_phase_in = 1'b0;
    logic        send           = 1'b0;
    logic [2:0]  kind           = 3'h0;
    logic [4:0]  rail           = 5'h0;
    logic [55:0] cmd_rdata_out, d;
    logic [31:0] loop_comp_out;
    logic        cmd_rvalid_out, cmd_err_out, output_on_out, turn_off_start_out;
    logic        follow_active_out, follow_half_out, follow_ref_limit_out;
    logic        evt_valid_in;
    logic [2:0]  evt_type_in;
    logic [4:0]  evt_rail_in;
    int          failures = 0;
    int          checked  = 0;

    always #12.5 sys_clk_in = ~sys_clk_in;

    rstc_top DUT (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .cmd_wr_in(cmd_wr_in),
        .cmd_rd_in(cmd_rd_in), .cmd_code_in(cmd_code_in), .cmd_wdata_in(cmd_wdata_in),
        .cmd_rdata_out(cmd_rdata_out), .cmd_rvalid_out(cmd_rvalid_out), .cmd_err_out(cmd_err_out),
        .strap_kind_in(strap_kind_in), .strap_res_in(strap_res_in), .vin_meas_in(vin_meas_in),
        .vout_target_in(vout_target_in), .enable_pin_in(enable_pin_in), .op_enable_in(op_enable_in),
        .multi_phase_in(multi_phase_in), .evt_valid_in(evt_valid_in), .evt_type_in(evt_type_in),
        .evt_rail_in(evt_rail_in), .strap_order_in(strap_order_in), .output_on_out(output_on_out),
        .turn_off_start_out(turn_off_start_out), .loop_comp_out(loop_comp_out),
        .follow_active_out(follow_active_out), .follow_half_out(follow_half_out),
        .follow_ref_limit_out(follow_ref_limit_out));

    rstc_peer_rail peer (.sys_clk_in(sys_clk_in), .send_in(send), .kind_in(kind), .rail_in(rail),
        .evt_valid_out(evt_valid_in), .evt_type_out(evt_type_in), .evt_rail_out(evt_rail_in));

    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [55:0] got, input logic [55:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask : tick

    task automatic wr(input logic [7:0] code, input logic [55:0] data);
        tick(1);
        cmd_wr_in = 1'b1;
        cmd_code_in = code;
        cmd_wdata_in = data;
        tick(1);
        cmd_wr_in = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] code, input logic [55:0] exp);
        tick(1);
        cmd_rd_in = 1'b1;
        cmd_code_in = code;
        tick(1);
        cmd_rd_in = 1'b0;
        chk(cmd_rvalid_out, 1'b1);
        d = cmd_rdata_out;
        chk(d, exp);
    endtask : rd

    task automatic send_evt(input logic [2:0] k, input logic [4:0] r);
        tick(1);
        send = 1'b1;
        kind = k;
        rail = r;
        tick(1);
        send = 1'b0;
    endtask : send_evt

    // Output level must not move and no turn-off may start
    task automatic idle(input int n, input logic v);
        repeat (n) begin
            tick(1);
            chk(output_on_out, v);
            chk(turn_off_start_out, 1'b0);
        end
    endtask : idle

    task automatic wait_on(input logic want);
        int n;
        n = 0;
        while (output_on_out !== want && n < 20) begin
            tick(1);
            n++;
        end
        chk(output_on_out, want);
        if (n == 20) tally_and_finish();
    endtask : wait_on

    task automatic wait_stop;
        int n;
        n = 0;
        while (turn_off_start_out !== 1'b1 && n < 20) begin
            tick(1);
            n++;
        end
        chk(turn_off_start_out, 1'b1);
        if (n == 20) tally_and_finish();
        tick(1);
        chk({turn_off_start_out, output_on_out}, 2'b00);
    endtask : wait_stop

    ////////////////////////////////////////////////////////////////////////
    task automatic reset_values;
        rd(rstc_pkg::CMD_RAIL_ORDER, 56'h0);
        rd(rstc_pkg::CMD_FOLLOW, 56'h0);
        rd(rstc_pkg::CMD_LOOP_COMP, 56'h012A_0196);
        chk(d[31:24], 8'h01);
        vin_meas_in = 16'h5000;
        tick(2);
        chk({24'h0, loop_comp_out}, 56'h012D_0196);
        rd(8'h42, 56'h0);
        chk(cmd_err_out, 1'b1);
    endtask : reset_values

    task automatic strap_readback;
        rd(rstc_pkg::CMD_STRAP_READ, 56'h001E_05F3_F2F1_FF);
        wr(rstc_pkg::CMD_STRAP_READ, 56'h0);
        rd(rstc_pkg::CMD_STRAP_READ, 56'h001E_05F3_F2F1_FF);
    endtask : strap_readback

    task automatic loop_comp;
        wr(rstc_pkg::CMD_LOOP_COMP, 56'hFF_FFFF_FFFF);
        rd(rstc_pkg::CMD_LOOP_COMP, 56'h017F_FFFF);
        wr(rstc_pkg::CMD_LOOP_COMP, 56'h3456);
        vin_meas_in = 16'h1000;
        tick(4);
        rd(rstc_pkg::CMD_LOOP_COMP, 56'h3456);
        chk({24'h0, loop_comp_out}, 56'h3456);
    endtask : loop_comp

    task automatic order_override;
        strap_order_in = 16'hFFFF;
        tick(2);
        rd(rstc_pkg::CMD_RAIL_ORDER, 56'h9F9F);
        wr(rstc_pkg::CMD_RAIL_ORDER, 56'h6060);
        rd(rstc_pkg::CMD_RAIL_ORDER, 56'h0);
        wr(rstc_pkg::CMD_RAIL_ORDER, 56'hFFFF);
        rd(rstc_pkg::CMD_RAIL_ORDER, 56'h9F9F);
    endtask : order_override

    task automatic follow_cfg;
        vout_target_in = 16'h0D48;
        wr(rstc_pkg::CMD_FOLLOW, 56'hFF);
        tick(2);
        chk({follow_active_out, follow_half_out, follow_ref_limit_out}, 3'b111);
        rd(rstc_pkg::CMD_FOLLOW, 56'h86);
        wr(rstc_pkg::CMD_FOLLOW, 56'h80);
        tick(2);
        chk({follow_active_out, follow_half_out, follow_ref_limit_out}, 3'b100);
        multi_phase_in = 1'b1;
        tick(3);
        chk(follow_active_out, 1'b0);
        multi_phase_in = 1'b0;
    endtask : follow_cfg

    task automatic plain_on_off;
        wr(rstc_pkg::CMD_RAIL_ORDER, 56'h0);
        op_enable_in = 1'b1;
        wait_on(1'b1);
        op_enable_in = 1'b0;
        wait_stop();
    endtask : plain_on_off

    task automatic prequel;
        wr(rstc_pkg::CMD_RAIL_ORDER, 56'h8700);
        enable_pin_in = 1'b1;
        idle(10, 1'b0);
        send_evt(rstc_pkg::EVT_POWER_GOOD, 5'h03);
        send_evt(rstc_pkg::EVT_POWER_DOWN, 5'h07);
        idle(6, 1'b0);
        send_evt(rstc_pkg::EVT_POWER_GOOD, 5'h07);
        wait_on(1'b1);
    endtask : prequel

    task automatic sequel;
        wr(rstc_pkg::CMD_RAIL_ORDER, 56'h0089);
        enable_pin_in = 1'b0;
        idle(8, 1'b1);
        send_evt(rstc_pkg::EVT_POWER_DOWN, 5'h02);
        idle(6, 1'b1);
        send_evt(rstc_pkg::EVT_POWER_DOWN, 5'h09);
        wait_stop();
    endtask : sequel

    ////////////////////////////////////////////////////////////////////////
    initial begin
        tick(8);
        rst_n_in = 1'b1;
        tick(2);
        reset_values();
        strap_readback();
        loop_comp();
        order_override();
        follow_cfg();
        plain_on_off();
        prequel();
        sequel();
        tally_and_finish();
    end
endmodule : test_rail_sequence_track_config
`default_nettype wire

// ---- logic/rstc_event_match.sv ----
// Latches a rail event bus event of one type from one rail id
`timescale 1ns/1ps
`default_nettype none
module rstc_event_match (
    // Clock and reset
    input  wire logic       sys_clk_in,
    input  wire logic       rst_n_in,
    // Selection
    input  wire logic       enable_in,
    input  wire logic [4:0] rail_id_in,
    input  wire logic [2:0] type_in,
    input  wire logic       clear_in,
    // Event bus
    input  wire logic       evt_valid_in,
    input  wire logic [2:0] evt_type_in,
    input  wire logic [4:0] evt_rail_in,
    // Result
    output logic            seen_out
);
    logic seen_d;
    logic seen_q;
    logic hit;

    always_comb begin
        hit = enable_in && evt_valid_in && evt_type_in == type_in && evt_rail_in == rail_id_in;
        seen_d = seen_q;
        if (!enable_in) begin
            seen_d = 1'b0;
        end else if (hit) begin
            // Event wins over a clear in the same cycle
            seen_d = 1'b1;
        end else if (clear_in) begin
            seen_d = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            seen_q <= 1'b0;
        end else begin
            seen_q <= seen_d;
        end
    end

    assign seen_out = seen_q;

    event_catch_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (enable_in && evt_valid_in && evt_type_in == type_in && evt_rail_in == rail_id_in)
        |=> seen_out) else $error("matching event not latched"); // RULE10
endmodule : rstc_event_match
`default_nettype wire

// ---- logic/rstc_pkg.sv ----
// Constants and register layout for the rail sequence and tracking config bank
// Function
// RULE1: Strap readback: six decode bytes, low byte FF
// RULE2: Strap decode codes: resistor, low F1, open F2, high F3
// RULE3: Loop gain and residual automatic unless host writes
// RULE4: Loop comp word four bytes, reset from strap
// RULE5: Bit 24 enables compensation, resets one; 31:25 zero
// RULE6: Residual 23:16 capped 7Fh, gain 15:0
// RULE7: Prequel: turn on after enable and power-good
// RULE8: Sequel: start turn-off after sequel power-down event
// RULE9: Sequence word: prequel id 12:8, sequel id 4:0
// RULE10: Bit 15 prequel enable, bit 7 sequel enable
// RULE11: Written sequence word overrides strap configuration
// RULE12: Sequence word resets to zero, both modes off
// RULE13: Tracking only outside multi-phase sharing groups
// RULE14: Host sets tracker turn-off delay beyond tracked rail's
// RULE15: Host sets voltage command before enabling tracking
// RULE16: Tracking byte resets zero; bit 7 enable
// RULE17: Tracking bit 2: ratio 100 or 50 percent
// RULE18: Tracking bit 1: limit target or reference
// RULE19: Unused bits ignored on write, fixed on read
`default_nettype none
package rstc_pkg;
    localparam logic [7:0] CMD_STRAP_READ = 8'hDD;
    localparam logic [7:0] CMD_LOOP_COMP  = 8'hDF;
    localparam logic [7:0] CMD_RAIL_ORDER = 8'hE0;
    localparam logic [7:0] CMD_FOLLOW     = 8'hE1;

    localparam logic [7:0] STRAP_LOW     = 8'hF1;
    localparam logic [7:0] STRAP_OPEN    = 8'hF2;
    localparam logic [7:0] STRAP_HIGH    = 8'hF3;
    localparam logic [7:0] STRAP_RES_MAX = 8'h1E;
    localparam logic [7:0] STRAP_FILL    = 8'hFF;

    localparam logic [1:0] PIN_LOW  = 2'h0;
    localparam logic [1:0] PIN_OPEN = 2'h1;
    localparam logic [1:0] PIN_HIGH = 2'h2;
    localparam logic [1:0] PIN_RES  = 2'h3;

    localparam logic [31:0] LOOP_MASK   = 32'h017F_FFFF;
    localparam logic [31:0] LOOP_RESET  = 32'h0100_0000;
    localparam int          LOOP_EN_BIT = 24;
    localparam logic [7:0]  RESID_MAX   = 8'h7F;
    localparam logic [15:0] ORDER_MASK  = 16'h9F9F;
    localparam logic [15:0] ORDER_RESET = 16'h0000;
    localparam int          PRE_EN_BIT  = 15;
    localparam int          SEQ_EN_BIT  = 7;
    localparam logic [7:0]  FOLLOW_MASK = 8'h86;
    localparam logic [7:0]  FOLLOW_RESET = 8'h00;
    localparam int          FOL_EN_BIT  = 7;
    localparam int          FOL_HALF_BIT = 2;
    localparam int          FOL_LIM_BIT = 1;

    localparam logic [2:0] EVT_POWER_GOOD = 3'h1;
    localparam logic [2:0] EVT_POWER_DOWN = 3'h2;

    localparam logic [7:0] AUTO_RESID_BASE = 8'h28;
    localparam logic [15:0] AUTO_GAIN_BASE = 16'h00C8;
endpackage : rstc_pkg
`default_nettype wire

// ---- logic/rstc_strap_decode.sv ----
// Converts one strap pin's measured condition to its decode byte
`timescale 1ns/1ps
`default_nettype none
module rstc_strap_decode (
    // Clock and reset
    input  wire logic       sys_clk_in,
    input  wire logic       rst_n_in,
    // Measured condition
    input  wire logic [1:0] kind_in,
    input  wire logic [4:0] res_index_in,
    // Decode byte
    output logic      [7:0] code_out
);
    logic [7:0] code_d;
    logic [7:0] code_q;

    always_comb begin
        unique case (kind_in)
            rstc_pkg::PIN_LOW:  code_d = rstc_pkg::STRAP_LOW; // RULE2
            rstc_pkg::PIN_OPEN: code_d = rstc_pkg::STRAP_OPEN; // RULE2
            rstc_pkg::PIN_HIGH: code_d = rstc_pkg::STRAP_HIGH; // RULE2
            rstc_pkg::PIN_RES: begin
                // Resistor codes saturate at the top table entry
                if ({3'h0, res_index_in} > rstc_pkg::STRAP_RES_MAX) begin
                    code_d = rstc_pkg::STRAP_RES_MAX; // RULE2
                end else begin
                    code_d = {3'h0, res_index_in}; // RULE2
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            code_q <= rstc_pkg::STRAP_OPEN;
        end else begin
            code_q <= code_d;
        end
    end

    assign code_out = code_q;

    strap_range_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        code_out <= rstc_pkg::STRAP_RES_MAX || code_out == rstc_pkg::STRAP_LOW
        || code_out == rstc_pkg::STRAP_OPEN || code_out == rstc_pkg::STRAP_HIGH)
        else $error("strap decode out of range"); // RULE2
endmodule : rstc_strap_decode
`default_nettype wire

// ---- logic/rstc_top.sv ----
// Configuration bank: strap readback, loop compensation, sequencing, tracking
`timescale 1ns/1ps
`default_nettype none
module rstc_top (
    // Clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        rst_n_in,
    // Command port
    input  wire logic        cmd_wr_in,
    input  wire logic        cmd_rd_in,
    input  wire logic [7:0]  cmd_code_in,
    input  wire logic [55:0] cmd_wdata_in,
    output logic      [55:0] cmd_rdata_out,
    output logic             cmd_rvalid_out,
    output logic             cmd_err_out,
    // Strap pin conditions, six pins, pin 5 is loop comp
    input  wire logic [11:0] strap_kind_in,
    input  wire logic [29:0] strap_res_in,
    // Operating inputs
    input  wire logic [15:0] vin_meas_in,
    input  wire logic [15:0] vout_target_in,
    input  wire logic        enable_pin_in,
    input  wire logic        op_enable_in,
    input  wire logic        multi_phase_in,
    // Rail event bus
    input  wire logic        evt_valid_in,
    input  wire logic [2:0]  evt_type_in,
    input  wire logic [4:0]  evt_rail_in,
    // Strap derived sequencing
    input  wire logic [15:0] strap_order_in,
    // Control outputs
    output logic             output_on_out,
    output logic             turn_off_start_out,
    output logic [31:0]      loop_comp_out,
    output logic             follow_active_out,
    output logic             follow_half_out,
    output logic             follow_ref_limit_out
);
    ////////////////////////////////////////////////////////////////////////
    // Enable pin synchroniser: three stages, change on agreement of last two
    logic [2:0] en_pin_s_q;
    logic [2:0] en_pin_s_d;
    logic       en_pin_q;
    logic       en_pin_d;

    always_comb begin
        en_pin_s_d = {en_pin_s_q[1:0], enable_pin_in};
        en_pin_d = en_pin_q;
        if (en_pin_s_q[2] == en_pin_s_q[1]) begin
            en_pin_d = en_pin_s_q[2];
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            en_pin_s_q <= 3'h0;
            en_pin_q   <= 1'b0;
        end else begin
            en_pin_s_q <= en_pin_s_d;
            en_pin_q   <= en_pin_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Strap decoders
    logic [47:0] strap_codes;

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_strap
            rstc_strap_decode u_dec (
                .sys_clk_in   (sys_clk_in),
                .rst_n_in     (rst_n_in),
                .kind_in      (strap_kind_in[2*gi +: 2]),
                .res_index_in (strap_res_in[5*gi +: 5]),
                .code_out     (strap_codes[8*gi +: 8])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers
    logic [31:0] loop_d;
    logic [31:0] loop_q;
    logic        loop_user_d;
    logic        loop_user_q;
    logic        loop_init_d;
    logic        loop_init_q;
    logic [15:0] order_d;
    logic [15:0] order_q;
    logic        order_user_d;
    logic        order_user_q;
    logic [7:0]  follow_d;
    logic [7:0]  follow_q;
    logic [7:0]  resid_auto;
    logic [15:0] gain_auto;
    logic [7:0]  resid_wr;
    logic [15:0] order_eff;

    always_comb begin
        // Automatic values grow with conversion ratio terms
        gain_auto  = rstc_pkg::AUTO_GAIN_BASE + {4'h0, vout_target_in[15:4]};
        resid_auto = rstc_pkg::AUTO_RESID_BASE + {4'h0, vin_meas_in[15:12]};
        if (resid_auto > rstc_pkg::RESID_MAX) begin
            resid_auto = rstc_pkg::RESID_MAX;
        end
        resid_wr = cmd_wdata_in[23:16];
        if (resid_wr > rstc_pkg::RESID_MAX) begin
            resid_wr = rstc_pkg::RESID_MAX; // RULE6
        end
        loop_d       = loop_q;
        loop_user_d  = loop_user_q;
        loop_init_d  = 1'b1;
        order_d      = order_q;
        order_user_d = order_user_q;
        follow_d     = follow_q;
        if (!loop_init_q) begin
            // Strap decode seeds residual low seven bits and gain low byte
            loop_d = {7'h00, 1'b1, 1'b0, strap_codes[46:40], 8'h00, strap_codes[47:40]}; // RULE4 RULE5
        end else if (!loop_user_q) begin
            loop_d = {7'h00, loop_q[rstc_pkg::LOOP_EN_BIT], resid_auto, gain_auto}; // RULE3
        end
        if (cmd_wr_in) begin
            unique case (cmd_code_in)
                rstc_pkg::CMD_LOOP_COMP: begin
                    loop_d = {cmd_wdata_in[31:24], resid_wr, cmd_wdata_in[15:0]}
                        & rstc_pkg::LOOP_MASK; // RULE5 RULE6 RULE19
                    loop_user_d = 1'b1; // RULE3
                end
                rstc_pkg::CMD_RAIL_ORDER: begin
                    order_d = cmd_wdata_in[15:0] & rstc_pkg::ORDER_MASK; // RULE9 RULE19
                    order_user_d = 1'b1; // RULE11
                end
                rstc_pkg::CMD_FOLLOW: begin
                    follow_d = cmd_wdata_in[7:0] & rstc_pkg::FOLLOW_MASK; // RULE16 RULE19
                end
                default: begin
                end
            endcase
        end
        order_eff = order_user_q ? order_q : (strap_order_in & rstc_pkg::ORDER_MASK); // RULE11
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            loop_q       <= rstc_pkg::LOOP_RESET;
            loop_user_q  <= 1'b0;
            loop_init_q  <= 1'b0;
            order_q      <= rstc_pkg::ORDER_RESET; // RULE12
            order_user_q <= 1'b0;
            follow_q     <= rstc_pkg::FOLLOW_RESET; // RULE16
        end else begin
            loop_q       <= loop_d;
            loop_user_q  <= loop_user_d;
            loop_init_q  <= loop_init_d;
            order_q      <= order_d;
            order_user_q <= order_user_d;
            follow_q     <= follow_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path
    logic [55:0] rdata_d;
    logic [55:0] rdata_q;
    logic        rvalid_d;
    logic        rvalid_q;
    logic        err_d;
    logic        err_q;

    always_comb begin
        rdata_d  = rdata_q;
        rvalid_d = 1'b0;
        err_d    = 1'b0;
        if (cmd_rd_in) begin
            rvalid_d = 1'b1;
            unique case (cmd_code_in)
                rstc_pkg::CMD_STRAP_READ: rdata_d = {strap_codes, rstc_pkg::STRAP_FILL}; // RULE1
                rstc_pkg::CMD_LOOP_COMP:  rdata_d = {24'h000000, loop_q}; // RULE4
                rstc_pkg::CMD_RAIL_ORDER: rdata_d = {40'h0000000000, order_eff}; // RULE9
                rstc_pkg::CMD_FOLLOW:     rdata_d = {48'h000000000000, follow_q}; // RULE16
                default: begin
                    rdata_d = 56'h00000000000000;
                    err_d   = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            rdata_q  <= 56'h00000000000000;
            rvalid_q <= 1'b0;
            err_q    <= 1'b0;
        end else begin
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
            err_q    <= err_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencing
    typedef enum logic [1:0] {
        RSTC_OFF     = 2'b00,
        RSTC_ON      = 2'b01,
        RSTC_DRAIN   = 2'b11
    } rstc_seq_t;

    rstc_seq_t   seq_d;
    rstc_seq_t   seq_q;
    logic        pre_en;
    logic        sq_en;
    logic        pre_seen;
    logic        sq_seen;
    logic        want_on;
    logic        on_d;
    logic        on_q;
    logic        toff_d;
    logic        toff_q;

    assign pre_en = order_eff[rstc_pkg::PRE_EN_BIT];
    assign sq_en  = order_eff[rstc_pkg::SEQ_EN_BIT];

    rstc_event_match u_pre (
        .sys_clk_in   (sys_clk_in),
        .rst_n_in     (rst_n_in),
        .enable_in    (pre_en),
        .rail_id_in   (order_eff[12:8]),
        .type_in      (rstc_pkg::EVT_POWER_GOOD),
        .clear_in     (seq_q == RSTC_OFF && !want_on),
        .evt_valid_in (evt_valid_in),
        .evt_type_in  (evt_type_in),
        .evt_rail_in  (evt_rail_in),
        .seen_out     (pre_seen)
    );

    rstc_event_match u_seq (
        .sys_clk_in   (sys_clk_in),
        .rst_n_in     (rst_n_in),
        .enable_in    (sq_en),
        .rail_id_in   (order_eff[4:0]),
        .type_in      (rstc_pkg::EVT_POWER_DOWN),
        .clear_in     (seq_q == RSTC_ON && want_on),
        .evt_valid_in (evt_valid_in),
        .evt_type_in  (evt_type_in),
        .evt_rail_in  (evt_rail_in),
        .seen_out     (sq_seen)
    );

    always_comb begin
        want_on = en_pin_q || op_enable_in;
        seq_d   = seq_q;
        on_d    = 1'b0;
        toff_d  = 1'b0;
        unique case (seq_q)
            RSTC_OFF: begin
                if (want_on && (!pre_en || pre_seen)) begin
                    seq_d = RSTC_ON; // RULE7 RULE10
                end
            end
            RSTC_ON: begin
                on_d = 1'b1;
                if (!want_on) begin
                    seq_d = RSTC_DRAIN;
                end
            end
            RSTC_DRAIN: begin
                on_d = 1'b1;
                if (want_on) begin
                    seq_d = RSTC_ON;
                end else if (!sq_en || sq_seen) begin
                    seq_d  = RSTC_OFF; // RULE8 RULE10
                    on_d   = 1'b0;
                    toff_d = 1'b1;
                end
            end
            default: seq_d = RSTC_OFF;
        endcase
        if (seq_d == RSTC_ON) begin
            on_d = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            seq_q  <= RSTC_OFF;
            on_q   <= 1'b0;
            toff_q <= 1'b0;
        end else begin
            seq_q  <= seq_d;
            on_q   <= on_d;
            toff_q <= toff_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Tracking controls
    logic fol_act_d;
    logic fol_act_q;
    logic fol_half_q;
    logic fol_lim_q;

    always_comb begin
        fol_act_d = follow_q[rstc_pkg::FOL_EN_BIT] && !multi_phase_in; // RULE13
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            fol_act_q  <= 1'b0;
            fol_half_q <= 1'b0;
            fol_lim_q  <= 1'b0;
        end else begin
            fol_act_q  <= fol_act_d;
            fol_half_q <= follow_q[rstc_pkg::FOL_HALF_BIT]; // RULE17
            fol_lim_q  <= follow_q[rstc_pkg::FOL_LIM_BIT]; // RULE18
        end
    end

    assign cmd_rdata_out        = rdata_q;
    assign cmd_rvalid_out       = rvalid_q;
    assign cmd_err_out          = err_q;
    assign output_on_out        = on_q;
    assign turn_off_start_out   = toff_q;
    assign loop_comp_out        = loop_q;
    assign follow_active_out    = fol_act_q;
    assign follow_half_out      = fol_half_q;
    assign follow_ref_limit_out = fol_lim_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    prequel_gate_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (seq_q == RSTC_OFF && seq_d == RSTC_ON && pre_en) |-> pre_seen && want_on)
        else $error("turned on without prequel power-good"); // RULE7

    sequel_gate_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (turn_off_start_out && $past(sq_en)) |-> $past(sq_seen))
        else $error("turn-off without sequel event"); // RULE8

    loop_fixed_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        loop_init_q |-> loop_comp_out[31:25] == 7'h00 && loop_comp_out[23:16] <= rstc_pkg::RESID_MAX)
        else $error("loop word unused bits or residual bad"); // RULE5

    loop_write_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (cmd_wr_in && cmd_code_in == rstc_pkg::CMD_LOOP_COMP)
        |=> loop_comp_out[15:0] == $past(cmd_wdata_in[15:0]))
        else $error("loop gain write lost"); // RULE6

    order_reset_a: assert property (@(posedge sys_clk_in)
        $rose(rst_n_in) |-> order_q == rstc_pkg::ORDER_RESET && follow_q == rstc_pkg::FOLLOW_RESET)
        else $error("config not reset"); // RULE12

    strap_read_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (cmd_rd_in && cmd_code_in == rstc_pkg::CMD_STRAP_READ)
        |=> cmd_rvalid_out && cmd_rdata_out[7:0] == rstc_pkg::STRAP_FILL)
        else $error("strap readback low byte wrong"); // RULE1

    follow_multi_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        multi_phase_in |=> !follow_active_out)
        else $error("tracking active in sharing group"); // RULE13

    follow_bits_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (follow_q & ~rstc_pkg::FOLLOW_MASK) == 8'h00 ##1 follow_half_out == $past(follow_q[rstc_pkg::FOL_HALF_BIT]))
        else $error("tracking byte fields wrong"); // RULE16 RULE17
endmodule : rstc_top
`default_nettype wire
